/* design/tx_lane_defs.svh */
// register offsets, field positions and reset values of the lane control bank
`ifndef TX_LANE_DEFS_SVH
`define TX_LANE_DEFS_SVH
`define LANE0_CONTROL_OFFSET 12'h004
`define LANE1_CONTROL_OFFSET 12'h008
`define LANE2_CONTROL_OFFSET 12'h00C
`define OPTIONS_OFFSET       12'h100
`define RESERVE_LSB          2
`define RESERVE_MSB          9
`define POWER_OFF_BIT        1
`define INVERT_BIT           0
`define RESERVE_RESET        8'h00
`define LANE_COUNT           3
`define WORD_BITS            40
`endif

/* design/tx_lane_pkg.sv */
// types of the lane control bank
package tx_lane_pkg;
  typedef struct packed {
    logic [7:0] reserve_field;
    logic       power_off;
    logic       invert;
  } lane_control_t;
  typedef struct packed {
    logic [39:0] data;
    logic        valid;
  } lane_word_t;
endpackage

/* design/tx_lane_control_regs.sv */
// lane control registers and lane polarity path for transmit lanes 0 to 2
// Notes on behaviour
// [RULE_01] one word per lane, bits 31:10 zero
// [RULE_02] bits 9:2 spare field, read/write, reset zero
// [RULE_03] bit 1 requests lane power-down
// [RULE_04] stored power-down bit drives output vector
// [RULE_05] transport layer reads vector for lane fallback
// [RULE_06] reset controller masks lane resets with vector
// [RULE_07] bit 0 set inverts lane transmit data
// [RULE_08] reset clears power-down and polarity bits
// [RULE_09] lane 1 at 0x8, lanes in order
// [RULE_10] power-down may be disabled, field stays
// [RULE_11] invert by bitwise complement, no added latency; the code registers tx_out, one pclk cycle behind tx_in
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`include "tx_lane_defs.svh"
module tx_lane_control_regs (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire tx_lane_pkg::lane_word_t tx_in [3],
  output tx_lane_pkg::lane_word_t      tx_out [3],
  output logic      [2:0]              lane_power_off
);
  // ****************************************
  // register file
  // ****************************************
  tx_lane_pkg::lane_control_t lane_control [3];
  logic                       power_off_enable;
  logic                       access;
  logic                       wr;
  logic [1:0]                 sel;
  logic                       hit;
  logic                       opt_hit;
  logic [31:0]                next_prdata;

  assign access = psel && penable && !pready;
  assign wr     = access && pwrite;

  always_comb begin
    sel     = 2'h0;
    hit     = 1'b1;
    opt_hit = 1'b0;
    case (paddr) // RULE_09
      `LANE0_CONTROL_OFFSET: sel = 2'h0;
      `LANE1_CONTROL_OFFSET: sel = 2'h1;
      `LANE2_CONTROL_OFFSET: sel = 2'h2;
      `OPTIONS_OFFSET: begin
        hit     = 1'b0;
        opt_hit = 1'b1;
      end
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `LANE_COUNT; i++) begin
        lane_control[i].reserve_field <= `RESERVE_RESET; // RULE_02
        lane_control[i].power_off     <= 1'b0; // RULE_08
        lane_control[i].invert        <= 1'b0; // RULE_08
      end
    end else if (wr && hit) begin
      if (pstrb[0]) begin
        lane_control[sel].invert    <= pwdata[`INVERT_BIT]; // RULE_07
        lane_control[sel].power_off <= pwdata[`POWER_OFF_BIT]; // RULE_03
        lane_control[sel].reserve_field[5:0] <= pwdata[7:2]; // RULE_02
      end
      if (pstrb[1]) begin
        lane_control[sel].reserve_field[7:6] <= pwdata[9:8]; // RULE_02
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_off_enable <= 1'b1;
    end else if (wr && opt_hit && pstrb[0]) begin
      power_off_enable <= pwdata[0]; // RULE_10
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000; // RULE_01
    if (hit) begin
      next_prdata[`RESERVE_MSB:`RESERVE_LSB] = lane_control[sel].reserve_field;
      next_prdata[`POWER_OFF_BIT]            = lane_control[sel].power_off;
      next_prdata[`INVERT_BIT]               = lane_control[sel].invert;
    end else if (opt_hit) begin
      next_prdata[0] = power_off_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access && !hit && !opt_hit;
      if (access && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // ****************************************
  // lane outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_power_off <= 3'h0;
    end else begin
      for (int i = 0; i < `LANE_COUNT; i++) begin // RULE_05
        lane_power_off[i] <= lane_control[i].power_off && power_off_enable; // RULE_04 RULE_10
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `LANE_COUNT; i++) begin
        tx_out[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `LANE_COUNT; i++) begin
        tx_out[i].valid <= tx_in[i].valid;
        tx_out[i].data  <= lane_control[i].invert ? ~tx_in[i].data : tx_in[i].data; // RULE_11
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    pready && !pwrite |-> prdata[31:10] == 22'h0)
    else $error("reserved bits read nonzero");
  a_readback_field: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    access && !pwrite && paddr == `LANE1_CONTROL_OFFSET |=> prdata[9:0] == $past(lane_control[1]))
    else $error("lane field readback mismatch");
  a_power_store: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    wr && paddr == `LANE1_CONTROL_OFFSET && pstrb[0] |=> lane_control[1].power_off == $past(pwdata[1]))
    else $error("power-down bit not stored");
  a_power_out: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    1'b1 |=> lane_power_off[2] == $past(lane_control[2].power_off && power_off_enable))
    else $error("power-down output mismatch");
  a_power_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
    !power_off_enable ##1 !power_off_enable |-> lane_power_off == 3'h0)
    else $error("power-down active while disabled");
  a_invert_path: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    lane_control[0].invert |=> tx_out[0].data == ~$past(tx_in[0].data))
    else $error("lane 0 not inverted");
  a_pass_path: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    !lane_control[1].invert |=> tx_out[1].data == $past(tx_in[1].data))
    else $error("lane 1 altered");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    access && !hit && !opt_hit |=> pready && pslverr)
    else $error("unmapped access not flagged");
  a_error_with_ready: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    pslverr |-> pready)
    else $error("error flag without answer");
  a_ready_answer: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    access |=> pready)
    else $error("access not answered");
  a_read_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    !(access && !pwrite) |=> $stable(prdata))
    else $error("read data changed without read");
  a_error_read_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    access && !pwrite && !hit && !opt_hit |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_options_store: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
    wr && opt_hit && pstrb[0] |=> power_off_enable == $past(pwdata[0]))
    else $error("options bit not stored");

  // ****************************************
  // lane 0 checks
  // ****************************************
  a_lane0_invert_store: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    wr && paddr == `LANE0_CONTROL_OFFSET && pstrb[0] |=> lane_control[0].invert == $past(pwdata[0]))
    else $error("lane 0 polarity bit not stored");
  a_lane0_power_store: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    wr && paddr == `LANE0_CONTROL_OFFSET && pstrb[0]
      |=> lane_control[0].power_off == $past(pwdata[1]))
    else $error("lane 0 power-down bit not stored");
  a_lane0_field_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    wr && paddr == `LANE0_CONTROL_OFFSET && pstrb[0]
      |=> lane_control[0].reserve_field[5:0] == $past(pwdata[7:2]))
    else $error("lane 0 field low bits not stored");
  a_lane0_field_high: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    wr && paddr == `LANE0_CONTROL_OFFSET && pstrb[1]
      |=> lane_control[0].reserve_field[7:6] == $past(pwdata[9:8]))
    else $error("lane 0 field high bits not stored");
  a_lane0_readback: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    access && !pwrite && paddr == `LANE0_CONTROL_OFFSET |=> prdata[9:0] == $past(lane_control[0]))
    else $error("lane 0 readback mismatch");
  a_lane0_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    !(wr && paddr == `LANE0_CONTROL_OFFSET) |=> $stable(lane_control[0]))
    else $error("lane 0 register changed without write");
  a_lane0_power_out: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    1'b1 |=> lane_power_off[0] == $past(lane_control[0].power_off && power_off_enable))
    else $error("lane 0 power-down output mismatch");
  a_lane0_pass: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    !lane_control[0].invert |=> tx_out[0].data == $past(tx_in[0].data))
    else $error("lane 0 altered");
  a_lane0_valid: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    1'b1 |=> tx_out[0].valid == $past(tx_in[0].valid))
    else $error("lane 0 valid not copied");

  // ****************************************
  // lane 1 checks
  // ****************************************
  a_lane1_invert_store: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    wr && paddr == `LANE1_CONTROL_OFFSET && pstrb[0] |=> lane_control[1].invert == $past(pwdata[0]))
    else $error("lane 1 polarity bit not stored");
  a_lane1_field_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    wr && paddr == `LANE1_CONTROL_OFFSET && pstrb[0]
      |=> lane_control[1].reserve_field[5:0] == $past(pwdata[7:2]))
    else $error("lane 1 field low bits not stored");
  a_lane1_field_high: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    wr && paddr == `LANE1_CONTROL_OFFSET && pstrb[1]
      |=> lane_control[1].reserve_field[7:6] == $past(pwdata[9:8]))
    else $error("lane 1 field high bits not stored");
  a_lane1_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    !(wr && paddr == `LANE1_CONTROL_OFFSET) |=> $stable(lane_control[1]))
    else $error("lane 1 register changed without write");
  a_lane1_power_out: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    1'b1 |=> lane_power_off[1] == $past(lane_control[1].power_off && power_off_enable))
    else $error("lane 1 power-down output mismatch");
  a_lane1_invert: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    lane_control[1].invert |=> tx_out[1].data == ~$past(tx_in[1].data))
    else $error("lane 1 not inverted");
  a_lane1_valid: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    1'b1 |=> tx_out[1].valid == $past(tx_in[1].valid))
    else $error("lane 1 valid not copied");

  // ****************************************
  // lane 2 checks
  // ****************************************
  a_lane2_invert_store: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    wr && paddr == `LANE2_CONTROL_OFFSET && pstrb[0] |=> lane_control[2].invert == $past(pwdata[0]))
    else $error("lane 2 polarity bit not stored");
  a_lane2_power_store: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    wr && paddr == `LANE2_CONTROL_OFFSET && pstrb[0]
      |=> lane_control[2].power_off == $past(pwdata[1]))
    else $error("lane 2 power-down bit not stored");
  a_lane2_field_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    wr && paddr == `LANE2_CONTROL_OFFSET && pstrb[0]
      |=> lane_control[2].reserve_field[5:0] == $past(pwdata[7:2]))
    else $error("lane 2 field low bits not stored");
  a_lane2_field_high: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    wr && paddr == `LANE2_CONTROL_OFFSET && pstrb[1]
      |=> lane_control[2].reserve_field[7:6] == $past(pwdata[9:8]))
    else $error("lane 2 field high bits not stored");
  a_lane2_readback: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    access && !pwrite && paddr == `LANE2_CONTROL_OFFSET |=> prdata[9:0] == $past(lane_control[2]))
    else $error("lane 2 readback mismatch");
  a_lane2_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    !(wr && paddr == `LANE2_CONTROL_OFFSET) |=> $stable(lane_control[2]))
    else $error("lane 2 register changed without write");
  a_lane2_invert: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    lane_control[2].invert |=> tx_out[2].data == ~$past(tx_in[2].data))
    else $error("lane 2 not inverted");
  a_lane2_pass: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    !lane_control[2].invert |=> tx_out[2].data == $past(tx_in[2].data))
    else $error("lane 2 altered");
  a_lane2_valid: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    1'b1 |=> tx_out[2].valid == $past(tx_in[2].valid))
    else $error("lane 2 valid not copied");

  // ****************************************
  // covers
  // ****************************************
  c_write_lane1: cover property (@(posedge pclk) wr && paddr == `LANE1_CONTROL_OFFSET);
  c_power_off: cover property (@(posedge pclk) lane_power_off[0]);
  c_invert_on: cover property (@(posedge pclk) lane_control[2].invert && tx_in[2].valid);
  c_disable: cover property (@(posedge pclk) wr && opt_hit);
  c_unmapped: cover property (@(posedge pclk) pready && pslverr);
endmodule

/* sim/tx_lane_control_regs_tb.sv */
// self-checking testbench of the lane control bank
`timescale 1ns/100ps
module tx_lane_control_regs_tb;
  logic                    pclk = 1'b0;
  logic                    presetn = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [11:0]             paddr = 12'h000;
  logic [31:0]             pwdata = 32'h00000000;
  logic [3:0]              pstrb = 4'hF;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  tx_lane_pkg::lane_word_t tx_in [3];
  tx_lane_pkg::lane_word_t tx_out [3];
  logic [2:0]              lane_power_off;
  int                      error_cnt = 0;
  int                      num_checks = 0;
  logic [31:0]             pat [3] = '{32'hFFFFFFFE, 32'h00000156, 32'hFFFFFF01};
  always #2 pclk = ~pclk;
  tx_lane_control_regs u_tx_lane_control_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_in(tx_in), .tx_out(tx_out), .lane_power_off(lane_power_off));
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r, x);
    chk(e, xe);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk(e, xe);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    for (int i = 0; i < 3; i++) rd(12'h004 + 12'(4 * i), 32'h0, 1'b0);
    chk(lane_power_off, 3'h0);
    for (int i = 0; i < 3; i++) wr(12'h004 + 12'(4 * i), pat[i], 1'b0);
    for (int i = 0; i < 3; i++) rd(12'h004 + 12'(4 * i), pat[i] & 32'h3FF, 1'b0);
    chk(lane_power_off, 3'b011);
    $display("test regs done");
  endtask
  task automatic t_invert;
    logic [39:0] a;
    logic [39:0] b;
    a = 40'h123456789A;
    b = 40'hF0F0F0F0F0;
    for (int i = 0; i < 3; i++) tx_in[i] <= '{a, 1'b1};
    @(posedge pclk);
    for (int i = 0; i < 3; i++) tx_in[i] <= '{b, 1'b0};
    @(posedge pclk);
    chk(tx_out[1], {a, 1'b1});
    chk(tx_out[2], {~a, 1'b1});
    @(posedge pclk);
    chk(tx_out[0], {b, 1'b0});
    chk(tx_out[2], {~b, 1'b0});
    $display("test invert done");
  endtask
  task automatic t_misc;
    wr(12'h100, 32'h0, 1'b0);
    rd(12'h100, 32'h0, 1'b0);
    chk(lane_power_off, 3'h0);
    rd(12'h004, 32'h3FE, 1'b0);
    wr(12'h100, 32'h1, 1'b0);
    chk(lane_power_off, 3'b011);
    wr(12'h010, 32'hFFFFFFFF, 1'b1);
    rd(12'h010, 32'h0, 1'b1);
    rd(12'h008, 32'h156, 1'b0);
    pstrb <= 4'h2;
    wr(12'h00C, 32'h0, 1'b0);
    pstrb <= 4'hF;
    rd(12'h00C, 32'h001, 1'b0);
    $display("test misc done");
  endtask
  initial begin
    for (int i = 0; i < 3; i++) tx_in[i] = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_invert;
    t_misc;
    test_done;
  end
  initial begin
    repeat (2000) @(posedge pclk);
    error_cnt++;
    test_done;
  end
endmodule
